// ---- rtl/hfx_top.sv ----
// Frame transmit and receive path: host strobe bus on mclk, serial link on serial_bit_clock.
// Assumes link pins change around serial_bit_clock and that the link clock runs during reset.
`include "hfx_defines.svh"
`default_nettype none

// Function
// RULE1 - Host flags packet end before last byte
// RULE2 - After end byte send check sequence, flag
// RULE3 - Queued next packet gets its own opening flag
// RULE4 - Empty after close returns to chosen idle
// RULE5 - Stuff zero after five ones, not flags
// RULE6 - Transmit bit zero of byte first
// RULE7 - Reset: receiver off, external timing, filter off
// RULE8 - Sample input, report recognised line states
// RULE9 - Collect after opening flag, delete stuffed zeros
// RULE10 - Store payload only, never flags or check
// RULE11 - Filter on: drop frame on address mismatch
// RULE12 - Matching or all-call address frames kept
// RULE13 - First received bit becomes bit zero
// RULE14 - Access spans later start to earlier end
// RULE15 - External clock runs at the bit rate
// RULE16 - Internal clock 2m or inverted 4m, rising
// RULE17 - Rate select: one equals, zero twice rate
// RULE18 - Write from idle starts frame with flag
// RULE19 - Empty before end: underrun flag, abort
// RULE20 - Flag 01111110, preset ones, complemented check
// RULE21 - Check residue, flag mismatch in status
module hfx_top
  import hfx_pkg::*;
(
  // System
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // Host strobe bus
  input  wire logic                 bus_cs_n,
  input  wire logic                 bus_e,
  input  wire logic                 bus_rw,
  input  wire logic [7:0]           bus_wdata,
  output logic      [7:0]           bus_rdata,
  input  wire logic                 packet_end_mark,
  // Configuration
  input  wire logic                 tx_enable,
  input  wire logic                 rx_enable,
  input  wire logic                 internal_timing,
  input  wire logic                 clock_rate_select,
  input  wire logic                 address_filter_enable,
  input  wire logic                 idle_fill_select,
  input  wire logic [7:0]           rx_address,
  input  wire logic [`HFX_ST_W-1:0] status_clear,
  // Status
  output logic      [`HFX_ST_W-1:0] status,
  output logic                      tx_ready,
  output logic                      rx_valid,
  // Serial link
  input  wire logic                 serial_bit_clock,
  input  wire logic                 serial_rx_in,
  input  wire logic                 frame_pulse_n,
  input  wire logic                 tx_cen_n,
  input  wire logic                 rx_cen_n,
  output logic                      serial_tx_out,
  output logic                      serial_tx_oe_n
);

  // ---------------- Host side (mclk) ----------------
  logic [10:0]          bus_s1;
  logic [10:0]          bus_s2;
  logic                 acc_d;
  logic                 acc_rw;
  logic [7:0]           acc_data;
  logic [8:0]           tx_hold;
  logic                 tx_req;
  logic [1:0]           tx_ack_s;
  logic                 rx_ack;
  logic [1:0]           rx_req_s;
  logic                 rx_seen;
  logic [`HFX_ST_W-1:0] ev_s1;
  logic [`HFX_ST_W-1:0] ev_s2;
  logic [`HFX_ST_W-1:0] ev_d;
  logic [7:0]           l_rx_byte;
  logic                 l_rx_req;
  logic                 l_tx_ack;
  logic                 l_unr_tog;
  logic [4:0]           l_rx_ev;

  // Access is open only while select is low and strobe high [RULE14]
  wire access     = !bus_s2[0] && bus_s2[1];
  wire access_end = acc_d && !access;
  wire do_write   = access_end && !acc_rw && tx_ready;
  wire do_read    = access_end && acc_rw && rx_valid;
  wire rx_arrive  = rx_req_s[1] != rx_seen;
  wire [`HFX_ST_W-1:0] ev_pulse = ev_s2 ^ ev_d;

  assign tx_ready = tx_req == tx_ack_s[1];

  always_ff @(posedge mclk)
  begin
    bus_s1   <= {bus_wdata, bus_rw, bus_e, bus_cs_n};
    bus_s2   <= bus_s1;
    acc_d    <= nrst && access;
    tx_ack_s <= {tx_ack_s[0], l_tx_ack};
    rx_req_s <= {rx_req_s[0], l_rx_req};
    ev_s1    <= {l_rx_ev, l_unr_tog};
    ev_s2    <= ev_s1;
    ev_d     <= ev_s2;
    if (access)
    begin
      acc_rw   <= bus_s2[2];
      acc_data <= bus_s2[10:3];
    end
  end

  // Writes while the byte slot is busy are dropped; end mark travels with the byte [RULE1]
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      tx_req    <= 1'b0;
      tx_hold   <= 9'h000;
      rx_valid  <= 1'b0;
      rx_seen   <= 1'b0;
      rx_ack    <= 1'b0;
      bus_rdata <= 8'h00;
      status    <= '0;
    end
    else
    begin
      if (do_write)
      begin
        tx_hold <= {packet_end_mark, acc_data};
        tx_req  <= !tx_req;
      end
      if (rx_arrive)
      begin
        bus_rdata <= l_rx_byte;
        rx_valid  <= 1'b1;
        rx_seen   <= rx_req_s[1];
      end
      else if (do_read)
      begin
        rx_valid <= 1'b0;
        rx_ack   <= rx_seen;
      end
      // Set wins over clear in the same cycle [RULE8] [RULE21]
      status <= (status & ~status_clear) | ev_pulse;
    end
  end

  // ---------------- Link side (serial_bit_clock) ----------------
  logic [1:0]       lrst_s;
  logic [13:0]      cfg_s1;
  logic [13:0]      cfg_s2;
  logic [3:0]       pin_s1;
  logic [3:0]       pin_s2;
  logic [1:0]       tx_req_s;
  logic [1:0]       rx_ack_s;
  logic             phase;
  hfx_tx_state_type tx_state;
  hfx_tx_state_type next_state;
  logic [7:0]       tx_sh;
  logic [7:0]       next_sh;
  logic [2:0]       tx_cnt;
  logic [2:0]       tx_ones;
  logic [15:0]      tx_crc;
  logic [15:0]      next_crc;
  logic             tx_end;
  logic             next_end;
  logic             take;
  logic             unr;

  wire lrst_n   = lrst_s[1];
  wire tx_on    = cfg_s2[0];
  wire rx_on    = cfg_s2[1];
  wire int_mode = cfg_s2[2];
  wire rate_one = cfg_s2[3];
  wire filt_on  = cfg_s2[4];
  wire fill_on  = cfg_s2[5];
  wire [7:0] rx_addr = cfg_s2[13:6];
  wire rxd      = pin_s2[0];
  wire fp_low   = !pin_s2[1];

  // Twice-rate clock uses every other rising edge, realigned by the frame pulse [RULE16] [RULE17]
  wire bit_en  = !int_mode || rate_one || phase;
  wire tx_lane = int_mode || !pin_s2[2];
  wire rx_lane = int_mode || !pin_s2[3];
  // External mode takes one bit per clock edge [RULE15]
  wire tx_tick = bit_en && tx_on && tx_lane;
  wire rx_tick = bit_en && rx_on && rx_lane;

  wire pending   = tx_req_s[1] != l_tx_ack;
  wire stuff_on  = tx_state == TX_DATA || tx_state == TX_FCS_LO || tx_state == TX_FCS_HI;
  // Run left by the last check byte still gets its zero before the closing flag
  wire stuff_now = tx_ones == `HFX_STUFF_RUN;
  wire tx_last   = tx_cnt == `HFX_LAST_BIT && !stuff_now;
  wire [7:0] fill = fill_on ? `HFX_FLAG : `HFX_MARK;

  always_ff @(posedge serial_bit_clock)
  begin
    lrst_s   <= {lrst_s[0], nrst};
    cfg_s1   <= {rx_address, idle_fill_select, address_filter_enable, clock_rate_select,
                 internal_timing, rx_enable, tx_enable};
    pin_s1   <= {rx_cen_n, tx_cen_n, frame_pulse_n, serial_rx_in};
    pin_s2   <= pin_s1;
    tx_req_s <= {tx_req_s[0], tx_req};
    rx_ack_s <= {rx_ack_s[0], rx_ack};
    // Cleared config means receiver off, external timing, filter off [RULE7]
    cfg_s2   <= lrst_n ? cfg_s1 : 14'h0000;
    phase    <= fp_low ? 1'b1 : !phase;
  end

  // Next frame element, chosen as the current byte finishes
  always_comb
  begin
    next_state = tx_state;
    next_sh    = fill;
    next_crc   = tx_crc;
    next_end   = tx_end;
    take       = 1'b0;
    unr        = 1'b0;
    unique case (tx_state)
      TX_IDLE, TX_CLOSE, TX_ABORT:
      begin
        // Flag before any data, also between packets [RULE3] [RULE18]; else idle or fill [RULE4]
        next_state = pending ? TX_OPEN : TX_IDLE;
        next_sh    = pending ? `HFX_FLAG : fill;
      end
      TX_OPEN, TX_DATA:
      begin
        if (tx_state == TX_DATA && tx_end)
        begin
          next_state = TX_FCS_LO;
          next_sh    = ~tx_crc[7:0];                                     // [RULE2] [RULE20]
        end
        else if (pending)
        begin
          next_state = TX_DATA;
          next_sh    = tx_hold[7:0];
          next_end   = tx_hold[8];
          next_crc   = hfx_crc_byte(tx_state == TX_OPEN ? `HFX_CRC_PRESET : tx_crc, tx_hold[7:0]);
          take       = 1'b1;
        end
        else
        begin
          next_state = TX_ABORT;                                         // [RULE19]
          next_sh    = `HFX_ABORT;
          unr        = 1'b1;
        end
      end
      TX_FCS_LO:
      begin
        next_state = TX_FCS_HI;
        next_sh    = ~tx_crc[15:8];
      end
      TX_FCS_HI:
      begin
        next_state = TX_CLOSE;                                           // [RULE2]
        next_sh    = `HFX_FLAG;
      end
      default:
      begin
        next_state = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge serial_bit_clock)
  begin
    if (!lrst_n)
    begin
      tx_state       <= TX_IDLE;
      tx_sh          <= `HFX_MARK;
      tx_cnt         <= 3'h0;
      tx_ones        <= 3'h0;
      tx_crc         <= `HFX_CRC_PRESET;
      tx_end         <= 1'b0;
      l_tx_ack       <= 1'b0;
      l_unr_tog      <= 1'b0;
      serial_tx_out  <= 1'b1;
      serial_tx_oe_n <= 1'b1;
    end
    else
    begin
      serial_tx_oe_n <= !(tx_on && tx_lane);
      if (tx_tick && stuff_now)
      begin
        serial_tx_out <= 1'b0;                                           // [RULE5]
        tx_ones       <= 3'h0;
      end
      else if (tx_tick)
      begin
        serial_tx_out <= tx_sh[0];                                       // [RULE6]
        tx_sh         <= tx_sh >> 1;
        tx_cnt        <= tx_cnt + 3'h1;
        tx_ones       <= (tx_sh[0] && stuff_on) ? tx_ones + 3'h1 : 3'h0;
        if (tx_last)
        begin
          tx_state  <= next_state;
          tx_sh     <= next_sh;
          tx_crc    <= next_crc;
          tx_end    <= next_end;
          l_tx_ack  <= l_tx_ack ^ take;
          l_unr_tog <= l_unr_tog ^ unr;
        end
      end
    end
  end

  // Receive
  logic [7:0]  rx_hist;
  logic [3:0]  rx_ones;
  logic        in_frame;
  logic [2:0]  rx_nb;
  logic [7:0]  rx_asm;
  logic [7:0]  rq0;
  logic [7:0]  rq1;
  logic [1:0]  rq_n;
  logic [3:0]  rx_bytes;
  logic [15:0] rx_crc;
  logic        rx_drop;

  wire [7:0] window    = {rxd, rx_hist[7:1]};
  wire       flag_det  = window == `HFX_FLAG;
  wire       abort_det = rxd && rx_ones == `HFX_ABORT_RUN;
  wire       del_bit   = !rxd && rx_ones[2:0] == `HFX_STUFF_RUN && !rx_ones[3];
  // First bit in lands at bit zero [RULE13]
  wire [7:0] byte_new  = {rxd, rx_asm[7:1]};
  wire       byte_done = rx_tick && in_frame && !flag_det && !abort_det && !del_bit && rx_nb == `HFX_LAST_BIT;
  wire       addr_bad  = filt_on && byte_new != rx_addr && byte_new != `HFX_ALLCALL;
  // Two bytes held back so the check sequence never leaves [RULE10]
  wire       emit      = byte_done && rq_n == 2'h2 && !rx_drop;
  wire       slot_full = l_rx_req != rx_ack_s[1];
  wire       close_ok  = in_frame && rx_bytes >= `HFX_MIN_BYTES && rx_nb == `HFX_LAST_BIT && !rx_drop;

  always_ff @(posedge serial_bit_clock)
  begin
    if (!lrst_n)
    begin
      rx_hist   <= 8'h00;
      rx_ones   <= 4'h0;
      in_frame  <= 1'b0;
      rx_nb     <= 3'h0;
      rx_asm    <= 8'h00;
      rq0       <= 8'h00;
      rq1       <= 8'h00;
      rq_n      <= 2'h0;
      rx_bytes  <= 4'h0;
      rx_crc    <= `HFX_CRC_PRESET;
      rx_drop   <= 1'b0;
      l_rx_req  <= 1'b0;
      l_rx_byte <= 8'h00;
      l_rx_ev   <= 5'h00;
    end
    else if (!rx_on)
    begin
      in_frame <= 1'b0;
    end
    else if (rx_tick)
    begin
      rx_hist <= window;
      rx_ones <= !rxd ? 4'h0 : (rx_ones == 4'hF ? rx_ones : rx_ones + 4'h1);
      if (flag_det)
      begin
        // Flag closes the old frame and opens a new one [RULE8] [RULE9] [RULE21]
        l_rx_ev[4] <= !l_rx_ev[4];
        l_rx_ev[0] <= l_rx_ev[0] ^ (close_ok && rx_crc == `HFX_CRC_GOOD);
        l_rx_ev[1] <= l_rx_ev[1] ^ (close_ok && rx_crc != `HFX_CRC_GOOD);
        in_frame   <= 1'b1;
        rx_nb      <= 3'h0;
        rq_n       <= 2'h0;
        rx_bytes   <= 4'h0;
        rx_crc     <= `HFX_CRC_PRESET;
        rx_drop    <= 1'b0;
      end
      else if (abort_det)
      begin
        // Ones after a closing flag are idle, not an abort
        l_rx_ev[2] <= l_rx_ev[2] ^ (in_frame && rx_bytes != 4'h0);
        in_frame   <= 1'b0;
      end
      else if (in_frame && !del_bit)                                     // [RULE9]
      begin
        rx_asm <= byte_new;
        rx_nb  <= rx_nb + 3'h1;
        if (byte_done)
        begin
          rx_crc   <= hfx_crc_byte(rx_crc, byte_new);
          rx_bytes <= rx_bytes == 4'hF ? rx_bytes : rx_bytes + 4'h1;
          // Only the first byte is the address [RULE11] [RULE12]
          if (rx_bytes == 4'h0 && addr_bad)
          begin
            rx_drop <= 1'b1;
          end
          if (rq_n == 2'h2)
          begin
            rq0 <= rq1;
            rq1 <= byte_new;
          end
          else if (rq_n == 2'h1)
          begin
            rq1  <= byte_new;
            rq_n <= 2'h2;
          end
          else
          begin
            rq0  <= byte_new;
            rq_n <= 2'h1;
          end
          // Host still holds the last byte: lose the rest, hunt again
          if (emit && slot_full)
          begin
            l_rx_ev[3] <= !l_rx_ev[3];
            in_frame   <= 1'b0;
          end
          else if (emit)
          begin
            l_rx_byte <= rq0;                                            // [RULE10]
            l_rx_req  <= !l_rx_req;
          end
        end
      end
    end
  end

  // ---------------- Checks ----------------
  a_stuff_zero: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    tx_tick && stuff_now |=> !serial_tx_out) else $error("stuffed bit not zero"); // [RULE5]
  a_open_first: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    tx_state == TX_IDLE |=> tx_state != TX_DATA) else $error("data without opening flag"); // [RULE18]
  a_fcs_after: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    tx_tick && tx_last && tx_state == TX_DATA && tx_end |=> tx_state == TX_FCS_LO ##0 tx_sh == ~$past(tx_crc[7:0]))
    else $error("check sequence missing after end"); // [RULE2]
  a_close_after: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    tx_tick && tx_last && tx_state == TX_FCS_HI |=> tx_state == TX_CLOSE && tx_sh == `HFX_FLAG)
    else $error("closing flag missing"); // [RULE2]
  a_reopen_flag: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    tx_tick && tx_last && tx_state == TX_CLOSE && pending |=> tx_state == TX_OPEN)
    else $error("next packet not opened"); // [RULE3]
  a_idle_return: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    tx_tick && tx_last && tx_state == TX_CLOSE && !pending |=> tx_state == TX_IDLE && tx_sh == $past(fill))
    else $error("idle state not resumed"); // [RULE4]
  a_underrun_abort: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    tx_tick && tx_last && tx_state == TX_DATA && !tx_end && !pending |=> tx_state == TX_ABORT && l_unr_tog != $past(l_unr_tog))
    else $error("underrun not aborted"); // [RULE19]
  a_rate_half: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    int_mode && !rate_one && !fp_low && bit_en |=> !phase) else $error("twice rate not halved"); // [RULE17]
  a_reset_state: assert property (@(posedge serial_bit_clock)
    !lrst_n |=> !rx_on && !int_mode && !filt_on) else $error("reset config not cleared"); // [RULE7]
  a_drop_frame: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    rx_tick && byte_done && rx_bytes == 4'h0 && addr_bad && !flag_det |=> rx_drop) else $error("address mismatch kept"); // [RULE11]
  a_store_inframe: assert property (@(posedge serial_bit_clock) disable iff (!lrst_n)
    l_rx_req != $past(l_rx_req) |-> $past(in_frame) && !$past(rx_drop)) else $error("byte stored outside frame"); // [RULE9]

endmodule

`default_nettype wire

// ---- rtl/hfx_defines.svh ----
// Constants of the bit-oriented frame transmit and receive path.
// Assumes inclusion by the package and by the top module only.
`ifndef HFX_DEFINES_SVH
`define HFX_DEFINES_SVH

// Line patterns, sent and received LSB first
`define HFX_FLAG        8'h7E
`define HFX_MARK        8'hFF
`define HFX_ABORT       8'hFE
`define HFX_ALLCALL     8'hFF

// Check sequence, reflected form of x^16+x^12+x^5+1
`define HFX_CRC_PRESET  16'hFFFF
`define HFX_CRC_POLY    16'h8408
`define HFX_CRC_GOOD    16'hF0B8

// Bit run lengths
`define HFX_STUFF_RUN   3'h5
`define HFX_ABORT_RUN   4'h6
`define HFX_LAST_BIT    3'h7

// Shortest frame worth checking: one byte plus check sequence
`define HFX_MIN_BYTES   4'h3

// Status bit positions
`define HFX_ST_UNDERRUN 0
`define HFX_ST_GOOD     1
`define HFX_ST_FCS_ERR  2
`define HFX_ST_ABORT    3
`define HFX_ST_OVERFLOW 4
`define HFX_ST_FLAG     5
`define HFX_ST_W        6

`endif

// ---- rtl/hfx_pkg.sv ----
// Types and shared arithmetic of the frame path.
// Assumes hfx_defines.svh on the include path.
`include "hfx_defines.svh"
`default_nettype none

package hfx_pkg;

  typedef enum logic [2:0]
  {
    TX_IDLE   = 3'b000,
    TX_OPEN   = 3'b001,
    TX_DATA   = 3'b010,
    TX_FCS_LO = 3'b011,
    TX_FCS_HI = 3'b100,
    TX_CLOSE  = 3'b101,
    TX_ABORT  = 3'b110
  } hfx_tx_state_type;

  // One byte of check sequence, LSB first
  function automatic logic [15:0] hfx_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      c = (c[0] ^ data[i]) ? ((c >> 1) ^ `HFX_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

`default_nettype wire

// ---- testbench/hfx_link_model.sv ----
// Far side of the serial link: a free-running bit clock, a bit feeder and a capture.
// Assumes external timing with both channel enables held active.
`default_nettype none

module hfx_link_model
(
  // Link clock and strobes
  output logic      serial_bit_clock,
  output logic      tx_cen_n,
  output logic      rx_cen_n,
  output logic      frame_pulse_n,
  // Data
  output logic      serial_rx_in,
  input  wire logic serial_tx_out,
  input  wire logic serial_tx_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  bit rx_bits[$];
  bit cap[$];

  initial
  begin
    serial_bit_clock = 1'b0;
    tx_cen_n         = 1'b0;
    rx_cen_n         = 1'b0;
    frame_pulse_n    = 1'b1;
    serial_rx_in     = 1'b1;
  end

  // Backplane clock runs free, also through reset, one bit per period
  always #80 serial_bit_clock = ~serial_bit_clock;

  // Change data away from the sampling edge; idle line sends marks
  always @(negedge serial_bit_clock)
  begin
    serial_rx_in <= (rx_bits.size() > 0) ? rx_bits.pop_front() : 1'b1;
    if (serial_tx_oe_n === 1'b0)
      cap.push_back(serial_tx_out);
  end
endmodule

`default_nettype wire

// ---- testbench/hfx_top_tb.sv ----
// Self-checking bench of the frame path: strobe bus tasks and serial frame builder.
// Assumes hfx_link_model as far side in external timing mode, except one frame sent in internal timing at twice the bit rate.
`default_nettype none

module hfx_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       mclk, nrst, bus_cs_n, bus_e, bus_rw, packet_end_mark;
  logic [7:0] bus_wdata, bus_rdata, rx_address;
  logic       tx_enable, rx_enable, internal_timing, clock_rate_select;
  logic       address_filter_enable, idle_fill_select, tx_ready, rx_valid;
  logic [5:0] status_clear, status;
  wire        serial_bit_clock, serial_rx_in, frame_pulse_n, tx_cen_n, rx_cen_n;
  logic       serial_tx_out, serial_tx_oe_n;
  int         error_cnt;
  int         checks_done;
  bit         exp[$];
  int         ones;

  hfx_top u_hfx_top (.mclk(mclk), .nrst(nrst), .bus_cs_n(bus_cs_n), .bus_e(bus_e), .bus_rw(bus_rw),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .packet_end_mark(packet_end_mark), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .internal_timing(internal_timing), .clock_rate_select(clock_rate_select),
    .address_filter_enable(address_filter_enable), .idle_fill_select(idle_fill_select),
    .rx_address(rx_address), .status_clear(status_clear), .status(status), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .serial_bit_clock(serial_bit_clock), .serial_rx_in(serial_rx_in),
    .frame_pulse_n(frame_pulse_n), .tx_cen_n(tx_cen_n), .rx_cen_n(rx_cen_n),
    .serial_tx_out(serial_tx_out), .serial_tx_oe_n(serial_tx_oe_n));

  hfx_link_model u_hfx_link_model (.serial_bit_clock(serial_bit_clock), .tx_cen_n(tx_cen_n),
    .rx_cen_n(rx_cen_n), .frame_pulse_n(frame_pulse_n), .serial_rx_in(serial_rx_in),
    .serial_tx_out(serial_tx_out), .serial_tx_oe_n(serial_tx_oe_n));

  always #10 mclk = ~mclk;

  task automatic give_verdict();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic stop();
    error_cnt++;
    give_verdict();
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Order 1: strobe first, chip select last; ended by chip select
  task automatic bus_acc(input logic rw, input logic [7:0] d, input logic order);
    @(negedge mclk);
    bus_rw    = rw;
    bus_wdata = d;
    if (order) bus_e = 1'b1; else bus_cs_n = 1'b0;
    @(negedge mclk);
    if (order) bus_cs_n = 1'b0; else bus_e = 1'b1;
    repeat (4) @(negedge mclk);
    if (order) bus_cs_n = 1'b1; else bus_e = 1'b0;
    @(negedge mclk);
    bus_cs_n = 1'b1;
    bus_e    = 1'b0;
    repeat (4) @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] d, input logic last, input logic order);
    int n;
    for (n = 0; n < 4000 && tx_ready !== 1'b1; n++) @(negedge mclk);
    if (n == 4000) stop();
    packet_end_mark = last;
    bus_acc(1'b0, d, order);
    packet_end_mark = 1'b0;
  endtask

  task automatic rd(input logic [7:0] want);
    int n;
    for (n = 0; n < 4000 && rx_valid !== 1'b1; n++) @(negedge mclk);
    if (n == 4000) stop();
    chk(bus_rdata, want);
    bus_acc(1'b1, 8'h00, 1'b0);
  endtask

  task automatic bits(input int n);
    repeat (n * 8) @(negedge mclk);
  endtask

  task automatic clear_status();
    @(negedge mclk);
    status_clear = 6'h3F;
    @(negedge mclk);
    status_clear = 6'h00;
  endtask

  task automatic put_flag();
    for (int i = 0; i < 8; i++) exp.push_back(i != 0 && i != 7);
    ones = 0;
  endtask

  // Serial order bit 0 first, zero after five ones
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      exp.push_back(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (ones == 5)
      begin
        exp.push_back(1'b0);
        ones = 0;
      end
    end
  endtask

  // Own copy of the reflected check arithmetic, preset all ones, complement sent
  task automatic build(input logic [7:0] d[$], input bit bad);
    logic [15:0] c;
    exp.delete();
    put_flag();
    c = 16'hFFFF;
    foreach (d[k])
    begin
      put_byte(d[k]);
      for (int i = 0; i < 8; i++) c = (c[0] ^ d[k][i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    c = ~c ^ {15'h0000, bad};
    put_byte(c[7:0]);
    put_byte(c[15:8]);
    put_flag();
  endtask

  task automatic send();
    foreach (exp[i]) u_hfx_link_model.rx_bits.push_back(exp[i]);
  endtask

  function automatic logic found();
    for (int s = 0; s + exp.size() <= u_hfx_link_model.cap.size(); s++)
    begin
      int j;
      for (j = 0; j < exp.size() && u_hfx_link_model.cap[s + j] == exp[j]; j++);
      if (j == exp.size()) return 1'b1;
    end
    return 1'b0;
  endfunction

  initial
  begin
    mclk = 1'b0; nrst = 1'b0; bus_cs_n = 1'b1; bus_e = 1'b0; bus_rw = 1'b1;
    bus_wdata = 8'h00; packet_end_mark = 1'b0; tx_enable = 1'b0; rx_enable = 1'b0;
    internal_timing = 1'b0; clock_rate_select = 1'b0; address_filter_enable = 1'b0;
    idle_fill_select = 1'b0; rx_address = 8'h5A; status_clear = 6'h00;
    // Long enough for the link domain to see reset too
    repeat (40) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    chk(status, 16'h0000);
    chk({tx_ready, rx_valid, serial_tx_out, serial_tx_oe_n}, 16'h000B);
    repeat (40) @(negedge mclk);
    build('{8'h11, 8'h22}, 0);
    send();
    bits(90);
    chk(rx_valid, 16'h0000);
    rx_enable = 1'b1;
    tx_enable = 1'b1;
    bits(8);
    build('{8'h11, 8'hFF, 8'h7C}, 0);
    send();
    rd(8'h11);
    rd(8'hFF);
    rd(8'h7C);
    bits(40);
    chk(rx_valid, 16'h0000);
    chk(status[1], 16'h0001);
    chk(status[5], 16'h0001);
    chk(status[3], 16'h0000);
    clear_status();
    address_filter_enable = 1'b1;
    bits(4);
    build('{8'h33, 8'h01}, 0);
    send();
    build('{8'h5A, 8'h02}, 0);
    send();
    build('{8'hFF, 8'h03}, 0);
    send();
    rd(8'h5A);
    rd(8'h02);
    rd(8'hFF);
    rd(8'h03);
    build('{8'h5A, 8'h55}, 1);
    send();
    rd(8'h5A);
    rd(8'h55);
    bits(40);
    chk(status[2], 16'h0001);
    // Internal timing at twice the bit rate: each bit stands two link clocks
    internal_timing = 1'b1;
    bits(4);
    build('{8'h5A, 8'h3C}, 0);
    foreach (exp[i]) repeat (2) u_hfx_link_model.rx_bits.push_back(exp[i]);
    rd(8'h5A);
    rd(8'h3C);
    internal_timing = 1'b0;
    bits(4);
    // Eight ones inside a frame
    clear_status();
    exp.delete();
    put_flag();
    put_byte(8'h5A);
    repeat (8) exp.push_back(1'b1);
    send();
    bits(40);
    chk(status[3], 16'h0001);
    u_hfx_link_model.cap.delete();
    wr(8'hFF, 1'b0, 1'b0);
    wr(8'h3E, 1'b1, 1'b1);
    bits(80);
    build('{8'hFF, 8'h3E}, 0);
    chk(found(), 16'h0001);
    u_hfx_link_model.cap.delete();
    wr(8'h81, 1'b1, 1'b0);
    wr(8'h7E, 1'b0, 1'b0);
    wr(8'h01, 1'b1, 1'b1);
    bits(100);
    build('{8'h81}, 0);
    chk(found(), 16'h0001);
    build('{8'h7E, 8'h01}, 0);
    chk(found(), 16'h0001);
    chk(serial_tx_out, 16'h0001);
    idle_fill_select = 1'b1;
    bits(16);
    u_hfx_link_model.cap.delete();
    bits(40);
    exp.delete();
    put_flag();
    put_flag();
    chk(found(), 16'h0001);
    idle_fill_select = 1'b0;
    clear_status();
    // Packet left open so the line runs dry
    wr(8'h55, 1'b0, 1'b0);
    bits(60);
    chk(status[0], 16'h0001);
    clear_status();
    @(negedge mclk);
    chk(status[0], 16'h0000);
    give_verdict();
  end
endmodule

`default_nettype wire
